// ---- src/ofcr_regs.sv ----
/*
  ofcr_regs: register bank for the output formatter, with decoded output width.
  Assumes the register port master and the decimation mode come from logic on clk.
*/
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ps

module ofcr_regs (
  // clock and reset
  input  wire logic                    clk,
  input  wire logic                    rstn,
  // register port
  input  wire ofcr_pkg::ofcr_bus_type  bus,
  output logic [7:0]                   rdata,
  // operating mode from the decimation path
  input  wire ofcr_pkg::ofcr_mode_type mode,
  // configuration towards the output formatter
  output ofcr_pkg::ofcr_frame_clock_type      frame_clock_cfg,
  output ofcr_pkg::ofcr_map_type       mapping_cfg,
  output logic [1:0]                   output_clock_delay,
  output logic [4:0]                   output_width
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    ofcr_pkg::ofcr_frame_clock_type frame_clock;
    ofcr_pkg::ofcr_map_type  map;
    logic [1:0]              delay;
    logic [4:0]              width;
    logic [7:0]              rdata;
  } ofcr_state_type;

  ofcr_state_type state;
  ofcr_state_type next_state;

  // width chosen by the select field, falling back to a mode default on unused codes
  function automatic logic [4:0] ofcr_sel_width(input logic [2:0]  sel,
                                                input logic [4:0]  dflt);
    logic [4:0] w;
    w = dflt;
    case (sel)
      ofcr_pkg::res_sel_18: w = ofcr_pkg::width_18;
      ofcr_pkg::res_sel_16: w = ofcr_pkg::width_16;
      ofcr_pkg::res_sel_14: w = ofcr_pkg::width_14;
      default:              w = dflt;
    endcase
    return w;
  endfunction : ofcr_sel_width

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    next_state       = state;
    next_state.rdata = 8'h00;
    // register writes; reserved bits are dropped and read back as zero
    if (bus.wr) begin
      case (bus.addr)
        ofcr_pkg::frame_clock_cfg_offset: begin
          next_state.frame_clock.source  = bus.wdata[ofcr_pkg::frame_clock_source_pos];
          next_state.frame_clock.divide  = bus.wdata[ofcr_pkg::frame_clock_divide_pos];
          next_state.frame_clock.stretch = bus.wdata[ofcr_pkg::frame_clock_stretch_pos];
        end
        ofcr_pkg::output_resolution_mapping_offset: begin
          next_state.map.mapper_enable      = bus.wdata[ofcr_pkg::mapper_enable_pos];
          next_state.map.wide_output_enable = bus.wdata[ofcr_pkg::wide_output_enable_pos];
          next_state.map.output_resolution_select =
            bus.wdata[ofcr_pkg::output_resolution_select_pos +: 3];
        end
        ofcr_pkg::output_clock_delay_ctrl_offset: begin
          next_state.delay = bus.wdata[ofcr_pkg::output_clock_delay_pos +: 2];
        end
        default: begin
        end
      endcase
    end
    // effective width from the current settings and mode
    if (state.map.wide_output_enable) begin
      next_state.width = ofcr_pkg::width_20;
    end else begin
      case (mode)
        ofcr_pkg::ofcr_bypass: begin
          // select is ignored until software opens the mapper
          if (state.map.mapper_enable) begin
            next_state.width = ofcr_sel_width(state.map.output_resolution_select,
                                              ofcr_pkg::width_native);
          end else begin
            next_state.width = ofcr_pkg::width_native;
          end
        end
        ofcr_pkg::ofcr_real_decim: begin
          next_state.width = ofcr_sel_width(state.map.output_resolution_select,
                                            ofcr_pkg::width_18);
        end
        ofcr_pkg::ofcr_complex_decim: begin
          // code zero means "default" here, so the reset value keeps 16 bits
          if (state.map.output_resolution_select == ofcr_pkg::res_sel_18) begin
            next_state.width = ofcr_pkg::width_16;
          end else begin
            next_state.width = ofcr_sel_width(state.map.output_resolution_select,
                                              ofcr_pkg::width_16);
          end
        end
        default: next_state.width = ofcr_pkg::width_native;
      endcase
    end
    // read data stands one cycle after the read strobe
    if (bus.rd) begin
      case (bus.addr)
        ofcr_pkg::frame_clock_cfg_offset: begin
          next_state.rdata[ofcr_pkg::frame_clock_source_pos]  = state.frame_clock.source;
          next_state.rdata[ofcr_pkg::frame_clock_divide_pos]  = state.frame_clock.divide;
          next_state.rdata[ofcr_pkg::frame_clock_stretch_pos] = state.frame_clock.stretch;
        end
        ofcr_pkg::output_resolution_mapping_offset: begin
          next_state.rdata[ofcr_pkg::mapper_enable_pos]      = state.map.mapper_enable;
          next_state.rdata[ofcr_pkg::wide_output_enable_pos] = state.map.wide_output_enable;
          next_state.rdata[ofcr_pkg::output_resolution_select_pos +: 3] =
            state.map.output_resolution_select;
        end
        ofcr_pkg::output_clock_delay_ctrl_offset: begin
          next_state.rdata[ofcr_pkg::output_clock_delay_pos +: 2] = state.delay;
        end
        ofcr_pkg::format_status_offset: begin
          next_state.rdata = {3'h0, state.width}; // live effective width
        end
        default: next_state.rdata = 8'h00;
      endcase
    end
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge clk) begin
    if (!rstn) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  // outputs straight from the state flops
  assign rdata              = state.rdata;
  assign frame_clock_cfg    = state.frame_clock;
  assign mapping_cfg        = state.map;
  assign output_clock_delay = state.delay;
  assign output_width       = state.width;

  // ****************************************
  // assertions
  // ****************************************
  property p_mapper_gate;
    @(posedge clk) disable iff (!rstn)
      (mode == ofcr_pkg::ofcr_bypass && !state.map.mapper_enable
       && !state.map.wide_output_enable) |=> (output_width == ofcr_pkg::width_native);
  endproperty
  a_mapper_gate: assert property (p_mapper_gate) else $error("bypass width moved without mapper");

  property p_wide_no_mapper;
    @(posedge clk) disable iff (!rstn)
      (state.map.wide_output_enable && !state.map.mapper_enable)
      |=> (output_width == ofcr_pkg::width_20);
  endproperty
  a_wide_no_mapper: assert property (p_wide_no_mapper) else $error("20-bit needs no mapper");

  property p_wide_write;
    @(posedge clk) disable iff (!rstn)
      (bus.wr && bus.addr == ofcr_pkg::output_resolution_mapping_offset
       && bus.wdata[ofcr_pkg::wide_output_enable_pos])
      |=> ##1 (output_width == ofcr_pkg::width_20);
  endproperty
  a_wide_write: assert property (p_wide_write) else $error("wide bit did not give 20 bits");

  property p_sel_14;
    @(posedge clk) disable iff (!rstn)
      (!state.map.wide_output_enable && mode != ofcr_pkg::ofcr_bypass
       && state.map.output_resolution_select == ofcr_pkg::res_sel_14)
      |=> (output_width == ofcr_pkg::width_14);
  endproperty
  a_sel_14: assert property (p_sel_14) else $error("select 010 did not give 14 bits");

  property p_real_default;
    @(posedge clk) disable iff (!rstn)
      (!state.map.wide_output_enable && mode == ofcr_pkg::ofcr_real_decim
       && state.map.output_resolution_select == ofcr_pkg::res_sel_18)
      |=> (output_width == ofcr_pkg::width_18);
  endproperty
  a_real_default: assert property (p_real_default) else $error("real default not 18 bits");

  property p_complex_default;
    @(posedge clk) disable iff (!rstn)
      (!state.map.wide_output_enable && mode == ofcr_pkg::ofcr_complex_decim
       && state.map.output_resolution_select[2:1] == 2'h0)
      |=> (output_width == ofcr_pkg::width_16);
  endproperty
  a_complex_default: assert property (p_complex_default) else $error("complex not 16 bits");

  property p_delay_write;
    @(posedge clk) disable iff (!rstn)
      (bus.wr && bus.addr == ofcr_pkg::output_clock_delay_ctrl_offset)
      |=> (output_clock_delay == $past(bus.wdata[5:4]));
  endproperty
  a_delay_write: assert property (p_delay_write) else $error("clock delay not stored");

  property p_reset_clear;
    @(posedge clk) !rstn |=> (mapping_cfg == '0 && output_clock_delay == 2'h0
                              && frame_clock_cfg == '0 && rdata == 8'h00);
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("fields not cleared on reset");

  c_bypass_mapped: cover property (@(posedge clk) disable iff (!rstn)
    mode == ofcr_pkg::ofcr_bypass && state.map.mapper_enable ##1 output_width == 5'h10);
  c_wide: cover property (@(posedge clk) disable iff (!rstn) output_width == 5'h14);
  c_delay_max: cover property (@(posedge clk) disable iff (!rstn) output_clock_delay == 2'h3);
  c_status_read: cover property (@(posedge clk) disable iff (!rstn)
    bus.rd && bus.addr == 8'h1c ##1 rdata != 8'h00);

endmodule : ofcr_regs

// ---- inc/ofcr_pkg.sv ----
/*
  ofcr_pkg: shared constants and types for the output format configuration registers.
  Assumes a plain one-cycle register port on the single 200 MHz clock.
*/
package ofcr_pkg;

  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [7:0] frame_clock_cfg_offset           = 8'h19;
  localparam logic [7:0] output_resolution_mapping_offset = 8'h1b;
  localparam logic [7:0] output_clock_delay_ctrl_offset   = 8'h1e;
  localparam logic [7:0] format_status_offset             = 8'h1c;

  // ****************************************
  // field positions
  // ****************************************
  localparam int frame_clock_source_pos       = 7;
  localparam int frame_clock_divide_pos       = 4;
  localparam int frame_clock_stretch_pos      = 0;
  localparam int mapper_enable_pos            = 7;
  localparam int wide_output_enable_pos       = 6;
  localparam int output_resolution_select_pos = 3;
  localparam int output_clock_delay_pos       = 4;

  // ****************************************
  // reset values and codes
  // ****************************************
  localparam logic [7:0] reg_reset_value = 8'h00;
  localparam logic [2:0] res_sel_18      = 3'h0;
  localparam logic [2:0] res_sel_16      = 3'h1;
  localparam logic [2:0] res_sel_14      = 3'h2;
  localparam logic [4:0] width_20        = 5'h14;
  localparam logic [4:0] width_18        = 5'h12;
  localparam logic [4:0] width_16        = 5'h10;
  localparam logic [4:0] width_14        = 5'h0e;
  // native converter resolution, used when nothing remaps it
  localparam logic [4:0] width_native    = 5'h0e;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {ofcr_bypass, ofcr_real_decim, ofcr_complex_decim} ofcr_mode_type;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } ofcr_bus_type;

  typedef struct packed {
    logic       source;
    logic       divide;
    logic       stretch;
  } ofcr_frame_clock_type;

  typedef struct packed {
    logic       mapper_enable;
    logic       wide_output_enable;
    logic [2:0] output_resolution_select;
  } ofcr_map_type;

endpackage : ofcr_pkg

// ---- testbench/ofcr_regs_tb.sv ----
/*
  ofcr_regs_tb: self-checking bench for the output format register bank.
  Assumes ofcr_pkg is compiled first and reads answer in the cycle after the strobe.
*/
`timescale 1ns/1ps
module ofcr_regs_tb;
  logic                    clk;
  logic                    rstn;
  ofcr_pkg::ofcr_bus_type  bus;
  logic [7:0]              rdata;
  ofcr_pkg::ofcr_mode_type mode;
  ofcr_pkg::ofcr_frame_clock_type frame_clock_cfg;
  ofcr_pkg::ofcr_map_type  mapping_cfg;
  logic [1:0]              output_clock_delay;
  logic [4:0]              output_width;
  int                      failures = 0;
  int                      num_checks = 0;
  int                      cycles = 0;
  logic [31:0]             seed;
  logic [7:0]              d;
  logic [7:0]              v;

  ofcr_regs dut (.clk(clk), .rstn(rstn), .bus(bus), .rdata(rdata), .mode(mode),
    .frame_clock_cfg(frame_clock_cfg), .mapping_cfg(mapping_cfg),
    .output_clock_delay(output_clock_delay), .output_width(output_width));

  // ****************************************
  // model and helpers
  // ****************************************
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xorshift

  // expected width; unused select codes fall back to the mode default
  function automatic int exp_width(input int m, input int map, input int wide, input int sel);
    if (wide != 0) return 20;
    if (m == 1) return (sel == 1) ? 16 : (sel == 2) ? 14 : 18;
    if (m == 2) return (sel == 2) ? 14 : 16;
    if (m == 0 && map != 0) return (sel == 0) ? 18 : (sel == 1) ? 16 : 14;
    return 14;
  endfunction : exp_width

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // one-cycle write strobe, launched just after an edge
  task automatic wr(input logic [7:0] a, input logic [7:0] val);
    @(posedge clk);
    bus <= '{addr: a, wdata: val, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask : wr

  // data is taken in the single cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] val);
    @(posedge clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    #1 val = rdata;
  endtask : rd

  task automatic results;
    $display("checks=%0d failures=%0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : results

  // ****************************************
  // clock and hang guard
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // a full run needs about 720 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      results();
    end
  end

  // ****************************************
  // tests
  // ****************************************
  initial begin
    rstn = 1'b0;
    bus = '0;
    mode = ofcr_pkg::ofcr_bypass;
    seed = 32'h5595;
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    #1 chk({5'h00, frame_clock_cfg}, 8'h00);
    chk({3'h0, mapping_cfg}, 8'h00);
    chk({6'h00, output_clock_delay}, 8'h00);
    chk({3'h0, output_width}, 8'h0e);
    rd(8'h1b, d);
    chk(d, 8'h00);
    rd(8'h1e, d);
    chk(d, 8'h00);
    $display("test reset done");
    // random data, reserved bits dropped, read-only and unmapped places left alone
    for (int i = 0; i < 8; i++) begin
      seed = xorshift(seed);
      v = {seed[7:6], i[1:0], seed[3:0]};
      wr(8'h19, v);
      wr(8'h1b, v);
      wr(8'h1e, v);
      wr(8'h1c, ~v);
      wr(8'h55, v);
      rd(8'h19, d);
      chk(d, v & 8'h91);
      chk({5'h00, frame_clock_cfg}, {5'h00, v[7], v[4], v[0]});
      rd(8'h1b, d);
      chk(d, v & 8'hf8);
      rd(8'h1e, d);
      chk(d, v & 8'h30);
      chk({6'h00, output_clock_delay}, {6'h00, v[5:4]});
      rd(8'h1c, d);
      chk(d, 8'(exp_width(0, v[7], v[6], v[5:3])));
      rd(8'h55, d);
      chk(d, 8'h00);
      @(posedge clk);
      #1 chk(rdata, 8'h00);
    end
    $display("test registers done");
    // every mode against every mapper, wide and select setting
    for (int m = 0; m < 4; m++) begin
      // software keeps the frame clock table: 2-wire lane setting per mode
      wr(8'h19, (m == 2) ? 8'h80 : 8'h10);
      #1 chk({5'h00, frame_clock_cfg}, (m == 2) ? 8'h04 : 8'h02);
      for (int c = 0; c < 32; c++) begin
        @(posedge clk);
        mode <= ofcr_pkg::ofcr_mode_type'(m);
        wr(8'h1b, {c[4:0], 3'h0});
        @(posedge clk);
        #1 chk({3'h0, mapping_cfg}, {3'h0, c[4:0]});
        chk({3'h0, output_width}, 8'(exp_width(m, c[4], c[3], c[2:0])));
      end
    end
    $display("test width done");
    // second reset in mid-run clears every field
    wr(8'h1e, 8'h30);
    wr(8'h19, 8'h91);
    @(posedge clk);
    rstn <= 1'b0;
    @(posedge clk);
    rstn <= 1'b1;
    rd(8'h1e, d);
    chk(d, 8'h00);
    rd(8'h19, d);
    chk(d, 8'h00);
    rd(8'h1b, d);
    chk(d, 8'h00);
    $display("test second reset done");
    results();
  end
endmodule : ofcr_regs_tb
